// ---- anr_cfg.svh ----
/*
 Register offsets, field positions, reset and fixed values of the
 auto-negotiation ability register bank.
 Assumes inclusion by the package and the register module only.
*/
`ifndef ANR_CFG_SVH
`define ANR_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ANR_OFS_ADV       8'hC4
`define ANR_OFS_PARTNER   8'hC8
`define ANR_OFS_EXPANSION 8'hCC
`define ANR_OFS_MODE      8'hD0
`define ANR_OFS_NEG_CTRL  8'hE0
`define ANR_OFS_INT_STAT  8'hE4
`define ANR_OFS_INT_MASK  8'hE8

// ****************************************
// Field positions
// ****************************************
`define ANR_NEXT_PAGE_BIT 15
`define ANR_ACK_BIT       14
`define ANR_FAULT_BIT     13
`define ANR_PAUSE_BIT     10
`define ANR_FOUR_PAIR_BIT 9
`define ANR_FAST_FULL_BIT 8
`define ANR_FAST_HALF_BIT 7
`define ANR_SLOW_FULL_BIT 6
`define ANR_SLOW_HALF_BIT 5
`define ANR_PDF_BIT       4
`define ANR_PNP_BIT       3
`define ANR_OWN_NP_BIT    2
`define ANR_PR_BIT        1
`define ANR_PCAP_BIT      0
`define ANR_LONG_BIT      11
`define ANR_INT_PDF_BIT   0
`define ANR_INT_PR_BIT    1
`define ANR_INT_ACK_BIT   2

// ****************************************
// Reset and fixed values
// ****************************************
`define ANR_SELECTOR      5'h01
`define ANR_PARTNER_MASK  16'hE7FF
`define ANR_ADV_RST_ABIL  4'h7
`define ANR_NEG_EN_RST    1'b1
`define ANR_INT_W         3

`endif

// ---- anr_pkg.sv ----
/*
 Types shared by the auto-negotiation ability register bank.
 Assumes the configuration header is on the include path.
*/
`include "anr_cfg.svh"

package anr_pkg;

   typedef logic [15:0]           anr_word_t;
   typedef logic [`ANR_INT_W-1:0] anr_int_t;

endpackage : anr_pkg

// ---- anr_regs.sv ----
/*
 Auto-negotiation ability register bank: local advertisement, partner ability,
 expansion flags with clear-on-read latches, mode control, and an interrupt pair.
 Assumes the negotiation engine runs on core_clk and delivers each received
 link code word as a one-cycle strobe, so no synchroniser is needed on it.
*/
// Notes on behaviour
// - Own next-page ability bit of the advertisement reads zero and ignores writes.
// - Writable remote-fault advertise bit, reset zero, sent in the link code word.
// - Writable pause advertise bit announces symmetric pause in the code word.
// - The four-pair advertise bit is a constant zero.
// - Four writable speed and duplex advertise bits; lower three reset to one.
// - Advertisement selector field is read-only 00001.
// - Partner pause and speed abilities are read-only, reset zero, from its code word.
// - Partner acknowledge bit reads one once the partner code word acknowledges ours.
// - Partner remote-fault bit mirrors the received code word.
// - Partner selector field is read-only, reset zero.
// - Parallel-detection fault bit latches high and clears on read.
// - Page-received bit latches high on a new page and clears on read.
// - Expansion shows the partner next-page capability read-only.
// - Expansion own next-page bit always reads zero.
// - Expansion bit shows whether the partner can negotiate.
// - Writable long-reach bit, reset zero, selects reduced receive squelch.
// - Latching bits hold one from the event until read, then clear.
// - Advertisement only takes effect while negotiation is enabled.
`timescale 1ns/1ps
`include "anr_cfg.svh"

module anr_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic [ADDR_W-1:0]    avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic      [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic                 partner_word_valid,
   input  wire anr_pkg::anr_word_t   partner_word,
   input  wire logic                 parallel_detect_fault,
   input  wire logic                 partner_negotiation_capable,
   output anr_pkg::anr_word_t        adv_code_word,
   output logic                      negotiation_enable,
   output logic                      long_reach_squelch,
   output logic                      irq
);
   import anr_pkg::*;

   if (ADDR_W < 8) begin : g_addr_w_check
      $error("ADDR_W must be at least 8");
   end

   // ****************************************
   // Bus slave
   // ****************************************
   // Every access waits one cycle so that read data can come from a flop.
   logic        ack_reg;
   logic [31:0] rdata_reg;

   wire req      = avs_read | avs_write;
   wire rd_fire  = avs_read & ack_reg;
   wire wr_fire  = avs_write & ack_reg;
   wire lo_en    = avs_byteenable[0];
   wire hi_en    = avs_byteenable[1];
   wire in_page  = (ADDR_W == 8) || ((avs_address >> 8) == '0);
   wire [7:0] ofs = avs_address[7:0];

   wire sel_adv  = in_page && ofs == `ANR_OFS_ADV;
   wire sel_part = in_page && ofs == `ANR_OFS_PARTNER;
   wire sel_exp  = in_page && ofs == `ANR_OFS_EXPANSION;
   wire sel_mode = in_page && ofs == `ANR_OFS_MODE;
   wire sel_ctl  = in_page && ofs == `ANR_OFS_NEG_CTRL;
   wire sel_ist  = in_page && ofs == `ANR_OFS_INT_STAT;
   wire sel_msk  = in_page && ofs == `ANR_OFS_INT_MASK;

   wire wr_adv   = wr_fire & sel_adv;
   wire wr_mode  = wr_fire & sel_mode;
   wire wr_ctl   = wr_fire & sel_ctl;
   wire wr_msk   = wr_fire & sel_msk;
   wire rd_exp   = rd_fire & sel_exp;
   wire rd_ist   = rd_fire & sel_ist;

   assign avs_waitrequest = req & ~ack_reg;
   assign avs_readdata    = rdata_reg;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // ****************************************
   // Advertisement
   // ****************************************
   logic fault_adv_reg;
   logic neg_en_reg;
   logic pause_adv_reg;
   logic [3:0] abil_reg;
   anr_word_t adv_word;
   anr_word_t adv_out_reg;

   assign adv_word = {1'b0,
                      1'b0,
                      fault_adv_reg,
                      2'b00,
                      pause_adv_reg,
                      1'b0,
                      abil_reg,
                      `ANR_SELECTOR};

   // Only the documented writable bits are taken from a write.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fault_adv_reg <= 1'b0;
         pause_adv_reg <= 1'b1;
         abil_reg      <= `ANR_ADV_RST_ABIL;
      end else begin
         if (wr_adv && hi_en) begin
            fault_adv_reg <= avs_writedata[`ANR_FAULT_BIT];
            pause_adv_reg <= avs_writedata[`ANR_PAUSE_BIT];
            abil_reg[3]   <= avs_writedata[`ANR_FAST_FULL_BIT];
         end
         if (wr_adv && lo_en) begin
            abil_reg[2:0] <= avs_writedata[7:5];
         end
      end
   end

   // The engine sees nothing from the cycle after negotiation is switched off, so a stale
   // advertisement can never leak onto the cable.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         adv_out_reg <= 16'h0000;
      end else begin
         adv_out_reg <= neg_en_reg ? adv_word : 16'h0000;
      end
   end

   assign adv_code_word = adv_out_reg;

   // ****************************************
   // Mode and negotiation control
   // ****************************************
   logic long_reg;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         long_reg   <= 1'b0;
         neg_en_reg <= `ANR_NEG_EN_RST;
      end else begin
         if (wr_mode && hi_en) begin
            long_reg <= avs_writedata[`ANR_LONG_BIT];
         end
         if (wr_ctl && lo_en) begin
            neg_en_reg <= avs_writedata[0];
         end
      end
   end

   assign long_reach_squelch = long_reg;
   assign negotiation_enable = neg_en_reg;

   // ****************************************
   // Partner ability
   // ****************************************
   anr_word_t part_reg;
   wire       new_ack = partner_word_valid & partner_word[`ANR_ACK_BIT]
                        & ~part_reg[`ANR_ACK_BIT];

   // Reserved partner bits are masked so they always read zero.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         part_reg <= 16'h0000;
      end else if (partner_word_valid) begin
         part_reg <= partner_word & `ANR_PARTNER_MASK;
      end
   end

   // ****************************************
   // Expansion latches
   // ****************************************
   logic pdf_reg;
   logic pr_reg;

   // A read clears only what it returned, and a new event wins over the
   // clear, so an event landing in the read's acknowledge cycle is never lost.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pdf_reg <= 1'b0;
         pr_reg  <= 1'b0;
      end else begin
         pdf_reg <= parallel_detect_fault
                    | (pdf_reg & ~(rd_exp & rdata_reg[`ANR_PDF_BIT]));
         pr_reg  <= partner_word_valid
                    | (pr_reg & ~(rd_exp & rdata_reg[`ANR_PR_BIT]));
      end
   end

   anr_word_t exp_word;

   assign exp_word = {11'h000,
                      pdf_reg,
                      part_reg[`ANR_NEXT_PAGE_BIT],
                      1'b0,
                      pr_reg,
                      partner_negotiation_capable};

   // ****************************************
   // Interrupts
   // ****************************************
   anr_int_t ist_reg;
   anr_int_t msk_reg;
   anr_int_t ev;

   assign ev[`ANR_INT_PDF_BIT] = parallel_detect_fault;
   assign ev[`ANR_INT_PR_BIT]  = partner_word_valid;
   assign ev[`ANR_INT_ACK_BIT] = new_ack;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ist_reg <= '0;
         msk_reg <= '0;
      end else begin
         ist_reg <= ev | (ist_reg & ~(rd_ist ? rdata_reg[`ANR_INT_W-1:0] : '0));
         if (wr_msk && lo_en) begin
            msk_reg <= avs_writedata[`ANR_INT_W-1:0];
         end
      end
   end

   assign irq = |(ist_reg & msk_reg);

   // ****************************************
   // Read data
   // ****************************************
   anr_word_t rd_mux;

   assign rd_mux = sel_adv  ? adv_word :
                   sel_part ? part_reg :
                   sel_exp  ? exp_word :
                   sel_mode ? (16'h0000 | (16'(long_reg) << `ANR_LONG_BIT)) :
                   sel_ctl  ? 16'(neg_en_reg) :
                   sel_ist  ? 16'(ist_reg) :
                   sel_msk  ? 16'(msk_reg) :
                   16'h0000;

   // Captured in the wait cycle; the clear above uses this same snapshot.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read && !ack_reg) begin
         rdata_reg <= {16'h0000, rd_mux};
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_wait;
      req && avs_waitrequest;
   endsequence

   sequence s_done;
      !avs_waitrequest;
   endsequence

   property p_bus_answer;
      s_wait |=> s_done;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer not in two cycles");

   property p_own_np;
      !adv_code_word[15] && (!sel_adv || !rd_mux[15]);
   endproperty
   a_own_np: assert property (p_own_np)
      else $error("own next page bit set");

   sequence s_fault_wr;
      wr_adv && hi_en && avs_writedata[13] && neg_en_reg;
   endsequence

   property p_fault_adv;
      s_fault_wr |=> ##1 adv_code_word[13];
   endproperty
   a_fault_adv: assert property (p_fault_adv)
      else $error("remote fault not advertised");

   property p_fixed_adv;
      $past(neg_en_reg) && !$past(rst) |-> adv_code_word[4:0] == 5'h01 && !adv_code_word[9];
   endproperty
   a_fixed_adv: assert property (p_fixed_adv)
      else $error("fixed advertisement fields wrong");

   property p_neg_off;
      !$past(neg_en_reg) |-> adv_code_word == 16'h0000;
   endproperty
   a_neg_off: assert property (p_neg_off)
      else $error("advertisement sent while disabled");

   property p_ack;
      partner_word_valid && partner_word[14] |=> part_reg[14] && pr_reg;
   endproperty
   a_ack: assert property (p_ack)
      else $error("partner acknowledge not shown");

   property p_pdf_hold;
      parallel_detect_fault ##1 !rd_exp |=> pdf_reg;
   endproperty
   a_pdf_hold: assert property (p_pdf_hold)
      else $error("fault latch dropped without read");

   property p_pdf_clear;
      rd_exp && rdata_reg[4] && !parallel_detect_fault |=> !pdf_reg;
   endproperty
   a_pdf_clear: assert property (p_pdf_clear)
      else $error("fault latch not cleared by read");

   property p_irq;
      partner_word_valid && msk_reg[1] && !wr_msk |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("page interrupt missing");

   property p_pdf_set;
      parallel_detect_fault |=> pdf_reg;
   endproperty
   a_pdf_set: assert property (p_pdf_set)
      else $error("fault latch not set");

   sequence s_pr_read;
      rd_exp && rdata_reg[1] && !partner_word_valid;
   endsequence

   property p_pr_clear;
      s_pr_read |=> !pr_reg;
   endproperty
   a_pr_clear: assert property (p_pr_clear)
      else $error("page latch not cleared by read");

   property p_part_load;
      partner_word_valid |=> part_reg == ($past(partner_word) & `ANR_PARTNER_MASK);
   endproperty
   a_part_load: assert property (p_part_load)
      else $error("partner word not captured");

   property p_part_hold;
      !partner_word_valid |=> $stable(part_reg);
   endproperty
   a_part_hold: assert property (p_part_hold)
      else $error("partner ability changed without a page");

   property p_long_wr;
      wr_mode && hi_en |=> long_reach_squelch == $past(avs_writedata[`ANR_LONG_BIT]);
   endproperty
   a_long_wr: assert property (p_long_wr)
      else $error("long reach bit not written");

   property p_neg_wr;
      wr_ctl && lo_en |=> negotiation_enable == $past(avs_writedata[0]);
   endproperty
   a_neg_wr: assert property (p_neg_wr)
      else $error("negotiation enable not written");

   property p_exp_fixed;
      sel_exp |-> rd_mux[15:5] == 11'h000 && !rd_mux[2] && rd_mux[0] == partner_negotiation_capable;
   endproperty
   a_exp_fixed: assert property (p_exp_fixed)
      else $error("expansion fixed bits wrong");

endmodule : anr_regs

// ---- anr_link_partner.sv ----
/*
 Link partner model for the auto-negotiation ability register bank: it delivers
 received code word pages, parallel detection fault events and the partner's
 negotiation capable level.
 Assumes one clock, core_clk, shared with the register bank.
*/
`timescale 1ns/1ps

module anr_link_partner (
   input  wire logic          core_clk,
   output logic               partner_word_valid,
   output anr_pkg::anr_word_t partner_word,
   output logic               parallel_detect_fault,
   output logic               partner_negotiation_capable
);
   import anr_pkg::*;

   initial begin
      partner_word_valid          = 1'b0;
      partner_word                = 16'h5A5A;
      parallel_detect_fault       = 1'b0;
      partner_negotiation_capable = 1'b0;
   end

   // ****************************************
   // Page delivery
   // ****************************************
   // The word lines do not keep the last page after the strobe, so a bank that
   // samples them outside the strobe picks up a wrong value.
   task automatic send_page(input anr_word_t w);
      @(posedge core_clk);
      partner_word_valid <= 1'b1;
      partner_word       <= w;
      @(posedge core_clk);
      partner_word_valid <= 1'b0;
      partner_word       <= ~w;
   endtask : send_page

   task automatic fault_pulse();
      @(posedge core_clk);
      parallel_detect_fault <= 1'b1;
      @(posedge core_clk);
      parallel_detect_fault <= 1'b0;
   endtask : fault_pulse

   task automatic set_capable(input logic v);
      @(posedge core_clk);
      partner_negotiation_capable <= v;
   endtask : set_capable

endmodule : anr_link_partner

// ---- tb_top.sv ----
/*
 Self-checking testbench of the auto-negotiation ability register bank.
 Assumes the bank ends each Avalon request by lowering waitrequest.
*/
`timescale 1ns/1ps

module tb_top;
   import anr_pkg::*;

   typedef struct {logic wr; logic [7:0] a; logic [15:0] d; logic [3:0] be;} anr_row_t;

   logic        core_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic        partner_word_valid, parallel_detect_fault, partner_negotiation_capable;
   logic        negotiation_enable, long_reach_squelch, irq;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  avs_byteenable;
   anr_word_t   partner_word, adv_code_word;
   int          compares    = 0;
   int          miscompares = 0;

   // For reads the data column holds the expected register value.
   anr_row_t rows [16] = '{
      '{1'b0, 8'hC4, 16'h04E1, 4'h3}, '{1'b1, 8'hC4, 16'hFFFF, 4'h3},
      '{1'b0, 8'hC4, 16'h25E1, 4'h3}, '{1'b1, 8'hC4, 16'h0000, 4'h1},
      '{1'b0, 8'hC4, 16'h2501, 4'h3}, '{1'b0, 8'hD0, 16'h0000, 4'h3},
      '{1'b1, 8'hD0, 16'hFFFF, 4'h3}, '{1'b0, 8'hD0, 16'h0800, 4'h3},
      '{1'b1, 8'hC8, 16'hFFFF, 4'h3}, '{1'b0, 8'hC8, 16'h0000, 4'h3},
      '{1'b1, 8'hCC, 16'hFFFF, 4'h3}, '{1'b0, 8'hCC, 16'h0000, 4'h3},
      '{1'b1, 8'hF0, 16'hFFFF, 4'h3}, '{1'b0, 8'hF0, 16'h0000, 4'h3},
      '{1'b0, 8'hE0, 16'h0001, 4'h3}, '{1'b0, 8'hE8, 16'h0000, 4'h3}};

   anr_regs DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .partner_word_valid(partner_word_valid), .partner_word(partner_word),
      .parallel_detect_fault(parallel_detect_fault),
      .partner_negotiation_capable(partner_negotiation_capable), .adv_code_word(adv_code_word),
      .negotiation_enable(negotiation_enable), .long_reach_squelch(long_reach_squelch), .irq(irq));

   anr_link_partner P (.core_clk(core_clk), .partner_word_valid(partner_word_valid),
      .partner_word(partner_word), .parallel_detect_fault(parallel_detect_fault),
      .partner_negotiation_capable(partner_negotiation_capable));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_sim();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Signals change only by non-blocking assignment after a rising edge, so the
   // values read just after an edge are the ones that edge sampled.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] be, output logic [31:0] rdata);
      logic w;
      int   n;
      n     = 0;
      w     = 1'b1;
      rdata = 32'h0000_0000;
      @(posedge core_clk);
      avs_read       <= ~wr;
      avs_write      <= wr;
      avs_address    <= a;
      avs_writedata  <= {16'h0000, d};
      avs_byteenable <= be;
      while (w !== 1'b0 && n < 50) begin
         @(posedge core_clk);
         w     = avs_waitrequest;
         rdata = avs_readdata;
         n++;
      end
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (w !== 1'b0) begin
         miscompares++;
         end_sim();
      end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, d, 4'h3, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0000, 4'h3, q);
      chk($sformatf("register %h", a), q, {16'h0000, e});
   endtask : rd

   task automatic settle();
      repeat (3) @(negedge core_clk);
   endtask : settle

   // ****************************************
   // Clock, watchdog and main sequence
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      end_sim();
   end

   initial begin
      rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
      avs_writedata = 32'h0000_0000; avs_byteenable = 4'h0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         bus(rows[i].wr, rows[i].a, rows[i].d, rows[i].be, q);
         if (!rows[i].wr) chk($sformatf("row %0d", i), q, {16'h0000, rows[i].d});
      end
      settle();
      chk("adv_code_word", adv_code_word, 16'h2501);
      chk("long_reach_squelch", long_reach_squelch, 1'b1);
      wr(8'hE0, 16'h0000);
      settle();
      chk("negotiation_enable", negotiation_enable, 1'b0);
      chk("adv_code_word off", adv_code_word, 16'h0000);
      wr(8'hE0, 16'h0001);
      settle();
      chk("adv_code_word on", adv_code_word, 16'h2501);
      wr(8'hE8, 16'h0002);
      rd(8'hE8, 16'h0002);
      P.set_capable(1'b1);
      P.send_page(16'hFFFF);
      settle();
      chk("irq page", irq, 1'b1);
      rd(8'hC8, 16'hE7FF);
      rd(8'hCC, 16'h000B);
      rd(8'hCC, 16'h0009);
      rd(8'hE4, 16'h0006);
      settle();
      chk("irq cleared", irq, 1'b0);
      P.fault_pulse();
      settle();
      chk("irq masked", irq, 1'b0);
      rd(8'hCC, 16'h0019);
      rd(8'hCC, 16'h0009);
      rd(8'hE4, 16'h0001);
      P.set_capable(1'b0);
      P.send_page(16'h0001);
      rd(8'hC8, 16'h0001);
      rd(8'hCC, 16'h0002);
      rd(8'hE4, 16'h0002);
      wr(8'hC4, 16'h0000);
      rd(8'hC4, 16'h0001);
      settle();
      chk("adv_code_word cleared", adv_code_word, 16'h0001);
      bus(1'b1, 8'hD0, 16'h0000, 4'h1, q);
      rd(8'hD0, 16'h0800);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      settle();
      chk("adv_code_word reset", adv_code_word, 16'h04E1);
      chk("negotiation_enable reset", negotiation_enable, 1'b1);
      chk("long_reach_squelch reset", long_reach_squelch, 1'b0);
      chk("irq reset", irq, 1'b0);
      rd(8'hC4, 16'h04E1);
      rd(8'hC8, 16'h0000);
      rd(8'hCC, 16'h0000);
      rd(8'hD0, 16'h0000);
      rd(8'hE8, 16'h0000);
      end_sim();
   end

endmodule : tb_top
